// ==== common/jbst_defs.vh ====
`ifndef JBST_DEFS_VH
`define JBST_DEFS_VH

// ----------------------------------------
// Instruction register
// ----------------------------------------
`define JBST_IR_LEN        10
`define JBST_OP_SAMPLE     10'h005
`define JBST_OP_EXTEST     10'h00F
`define JBST_OP_BYPASS     10'h3FF
`define JBST_OP_USERCODE   10'h007
`define JBST_OP_IDCODE     10'h006
`define JBST_OP_HIGHZ      10'h00B
`define JBST_OP_CLAMP      10'h00A
`define JBST_OP_CHAIN_A    10'h00C
`define JBST_OP_CHAIN_B    10'h00E
`define JBST_OP_ISC_ENTER  10'h2CC
`define JBST_OP_ISC_EXIT   10'h201
`define JBST_IR_CAPTURE    10'h001

// ----------------------------------------
// Data registers
// ----------------------------------------
`define JBST_WORD_LEN      32
`define JBST_USERCODE_DFLT 32'hFFFF_FFFF
`define JBST_BSR_LEN       240
`define JBST_ID_VER_MSB    31
`define JBST_ID_VER_LSB    28
`define JBST_ID_PART_MSB   27
`define JBST_ID_PART_LSB   12
`define JBST_ID_MFR_MSB    11
`define JBST_ID_MFR_LSB    1
`define JBST_ID_LSB_VAL    1'b1

// ----------------------------------------
// Sampling and buffering
// ----------------------------------------
`define JBST_FIFO_DEPTH    8
`define JBST_FIFO_AW       3
`define JBST_FIFO_WIDTH    2

`endif

// ==== core/jbst_tap.v ====
`timescale 1ns/10ps
`include "jbst_defs.vh"

// ----------------------------------------
// Bit FIFO toward user logic
// ----------------------------------------
module jbst_fifo #(
  parameter WIDTH = `JBST_FIFO_WIDTH,
  parameter DEPTH = `JBST_FIFO_DEPTH,
  parameter AW    = `JBST_FIFO_AW
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;
  wire            push;
  wire            pop;

  assign in_ready  = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule // jbst_fifo

// ----------------------------------------
// Test access port
// ----------------------------------------
module jbst_tap #(
  parameter BSR_LEN  = `JBST_BSR_LEN,
  parameter NPIN     = BSR_LEN / 3,
  parameter [3:0]  ID_VERSION = 4'h0,
  // Arbitrary values, not any real part
  parameter [15:0] ID_PART    = 16'h1234,
  parameter [10:0] ID_MFR     = 11'h055
) (
  // Clock and reset
  input  wire            ref_clk,
  input  wire            rst_n,
  // Test port pins
  input  wire            tck,
  input  wire            tms,
  input  wire            tdi,
  output reg             tdo_r,
  output reg             tdo_oe_r,
  // Configuration
  input  wire [31:0]     usercode_cfg,
  input  wire            usercode_set,
  // Core and pad side
  input  wire [NPIN-1:0] pin_in,
  input  wire [NPIN-1:0] core_out,
  input  wire [NPIN-1:0] core_oe,
  output reg  [NPIN-1:0] pad_out_r,
  output reg  [NPIN-1:0] pad_oe_r,
  output reg             keeper_en_r,
  output reg             isc_mode_r,
  // User chain access
  output reg  [3:0]      user_state_r,
  output reg             user_sel_a_r,
  output reg             user_sel_b_r,
  output reg             user_tdi_r,
  output reg             user_capture_r,
  output reg             user_shift_r,
  output reg             user_update_r,
  input  wire            user_tdo_a,
  input  wire            user_tdo_b,
  // Shifted user bits, {chain_b, tdi}
  output wire            ubit_valid,
  input  wire            ubit_ready,
  output wire [1:0]      ubit_data
);
  localparam [3:0] S_EXIT2_DR = 4'h0, S_EXIT1_DR = 4'h1, S_SHIFT_DR = 4'h2;
  localparam [3:0] S_PAUSE_DR = 4'h3, S_SEL_IR   = 4'h4, S_UPD_DR   = 4'h5;
  localparam [3:0] S_CAP_DR   = 4'h6, S_SEL_DR   = 4'h7, S_EXIT2_IR = 4'h8;
  localparam [3:0] S_EXIT1_IR = 4'h9, S_SHIFT_IR = 4'hA, S_PAUSE_IR = 4'hB;
  localparam [3:0] S_IDLE     = 4'hC, S_UPD_IR   = 4'hD, S_CAP_IR   = 4'hE;
  localparam [3:0] S_RESET    = 4'hF;

  function [3:0] tap_next;
    input [3:0] st;
    input       m;
    begin
      case (st)
        S_RESET:    tap_next = m ? S_RESET    : S_IDLE;
        S_IDLE:     tap_next = m ? S_SEL_DR   : S_IDLE;
        S_SEL_DR:   tap_next = m ? S_SEL_IR   : S_CAP_DR;
        S_CAP_DR:   tap_next = m ? S_EXIT1_DR : S_SHIFT_DR;
        S_SHIFT_DR: tap_next = m ? S_EXIT1_DR : S_SHIFT_DR;
        S_EXIT1_DR: tap_next = m ? S_UPD_DR   : S_PAUSE_DR;
        S_PAUSE_DR: tap_next = m ? S_EXIT2_DR : S_PAUSE_DR;
        S_EXIT2_DR: tap_next = m ? S_UPD_DR   : S_SHIFT_DR;
        S_UPD_DR:   tap_next = m ? S_SEL_DR   : S_IDLE;
        S_SEL_IR:   tap_next = m ? S_RESET    : S_CAP_IR;
        S_CAP_IR:   tap_next = m ? S_EXIT1_IR : S_SHIFT_IR;
        S_SHIFT_IR: tap_next = m ? S_EXIT1_IR : S_SHIFT_IR;
        S_EXIT1_IR: tap_next = m ? S_UPD_IR   : S_PAUSE_IR;
        S_PAUSE_IR: tap_next = m ? S_EXIT2_IR : S_PAUSE_IR;
        S_EXIT2_IR: tap_next = m ? S_UPD_IR   : S_SHIFT_IR;
        S_UPD_IR:   tap_next = m ? S_SEL_DR   : S_IDLE;
        default:    tap_next = S_RESET;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------
  reg  [2:0]      tck_s_r;
  reg  [1:0]      tms_s_r;
  reg  [1:0]      tdi_s_r;
  reg  [NPIN-1:0] pin_m_r;
  reg  [NPIN-1:0] pin_s_r;
  reg             rise_pend_r;
  wire            tck_rise;
  wire            tck_fall;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      tck_s_r <= 3'h0;
      tms_s_r <= 2'h3;
      tdi_s_r <= 2'h0;
      pin_m_r <= {NPIN{1'b0}};
      pin_s_r <= {NPIN{1'b0}};
    end else begin
      tck_s_r <= {tck_s_r[1:0], tck};
      tms_s_r <= {tms_s_r[0], tms};
      tdi_s_r <= {tdi_s_r[0], tdi};
      pin_m_r <= pin_in;
      pin_s_r <= pin_m_r;
    end
  end

  assign tck_rise = tck_s_r[1] & ~tck_s_r[2];
  assign tck_fall = ~tck_s_r[1] & tck_s_r[2];

  // ----------------------------------------
  // Instruction decode
  // ----------------------------------------
  reg  [3:0]         state_r;
  reg  [9:0]         ir_sh_r;
  reg  [9:0]         ir_r;
  reg                byp_r;
  reg  [31:0]        word_r;
  reg  [BSR_LEN-1:0] bsr_r;
  reg  [BSR_LEN-1:0] upd_r;
  wire               sel_bsr;
  wire               sel_word;
  wire               sel_chain;
  wire               ir_known;
  wire               step;
  wire               ushift;
  wire               fifo_rdy;
  wire [3:0]         nxt;

  assign sel_bsr   = (ir_r == `JBST_OP_SAMPLE) | (ir_r == `JBST_OP_EXTEST);
  assign sel_word  = (ir_r == `JBST_OP_IDCODE) | (ir_r == `JBST_OP_USERCODE);
  assign sel_chain = (ir_r == `JBST_OP_CHAIN_A) | (ir_r == `JBST_OP_CHAIN_B);
  // unlisted codes fall back to bypass
  assign ir_known  = sel_bsr | sel_word | sel_chain;

  assign nxt    = tap_next(state_r, tms_s_r[1]);
  assign ushift = sel_chain & (state_r == S_SHIFT_DR);
  // A full FIFO delays the TCK rise; user logic must drain within a TCK period
  assign step   = (tck_rise | rise_pend_r) & ~(ushift & ~fifo_rdy);

  // ----------------------------------------
  // TCK rising edge: state and shift
  // ----------------------------------------
  integer i;
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      rise_pend_r <= 1'b0;
      state_r     <= S_RESET;
      ir_sh_r     <= 10'h000;
      byp_r       <= 1'b0;
      word_r      <= 32'h0000_0000;
      bsr_r       <= {BSR_LEN{1'b0}};
    end else begin
      rise_pend_r <= (tck_rise | rise_pend_r) & ~step;
      if (step) begin
        state_r <= nxt;
        case (state_r)
          S_CAP_IR: begin
            ir_sh_r <= `JBST_IR_CAPTURE;
          end
          S_SHIFT_IR: begin
            ir_sh_r <= {tdi_s_r[1], ir_sh_r[9:1]};
          end
          S_CAP_DR: begin
            byp_r <= 1'b0;
            if (ir_r == `JBST_OP_IDCODE) begin
              word_r <= {ID_VERSION, ID_PART, ID_MFR, `JBST_ID_LSB_VAL};
            end else if (usercode_set) begin
              word_r <= usercode_cfg;
            end else begin
              word_r <= `JBST_USERCODE_DFLT;
            end
            if (sel_bsr) begin
              for (i = 0; i < NPIN; i = i + 1) begin
                bsr_r[3*i]   <= pin_s_r[i];
                bsr_r[3*i+1] <= core_out[i];
                bsr_r[3*i+2] <= core_oe[i];
              end
            end
          end
          S_SHIFT_DR: begin
            byp_r <= tdi_s_r[1];
            if (sel_word) begin
              word_r <= {tdi_s_r[1], word_r[31:1]};
            end
            if (sel_bsr) begin
              bsr_r <= {tdi_s_r[1], bsr_r[BSR_LEN-1:1]};
            end
          end
          default: begin
            byp_r <= byp_r;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // TCK falling edge: updates and TDO
  // ----------------------------------------
  reg tdo_nxt;
  always @* begin
    tdo_nxt = byp_r;
    if (state_r == S_SHIFT_IR) begin
      tdo_nxt = ir_sh_r[0];
    end else if (sel_word) begin
      tdo_nxt = word_r[0];
    end else if (sel_bsr) begin
      tdo_nxt = bsr_r[0];
    end else if (ir_r == `JBST_OP_CHAIN_A) begin
      tdo_nxt = user_tdo_a;
    end else if (ir_r == `JBST_OP_CHAIN_B) begin
      tdo_nxt = user_tdo_b;
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      ir_r       <= `JBST_OP_IDCODE;
      upd_r      <= {BSR_LEN{1'b0}};
      tdo_r      <= 1'b0;
      tdo_oe_r   <= 1'b0;
      isc_mode_r <= 1'b0;
    end else if (tck_fall) begin
      tdo_r    <= tdo_nxt;
      tdo_oe_r <= (state_r == S_SHIFT_IR) | (state_r == S_SHIFT_DR);
      if (state_r == S_RESET) begin
        ir_r       <= `JBST_OP_IDCODE;
        isc_mode_r <= 1'b0;
      end else if (state_r == S_UPD_IR) begin
        ir_r <= ir_sh_r;
        if (ir_sh_r == `JBST_OP_ISC_ENTER) begin
          isc_mode_r <= 1'b1;
        end else if (ir_sh_r == `JBST_OP_ISC_EXIT) begin
          isc_mode_r <= 1'b0;
        end
      end
      if (state_r == S_UPD_DR && sel_bsr) begin
        upd_r <= bsr_r;
      end
    end
  end

  // ----------------------------------------
  // Pad drive
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : g_pad
      always @(posedge ref_clk) begin
        if (!rst_n) begin
          pad_out_r[g] <= 1'b0;
          pad_oe_r[g]  <= 1'b0;
        end else if ((ir_r == `JBST_OP_HIGHZ) || isc_mode_r) begin
          pad_out_r[g] <= 1'b0;
          pad_oe_r[g]  <= 1'b0;
        end else if ((ir_r == `JBST_OP_EXTEST) || (ir_r == `JBST_OP_CLAMP)) begin
          pad_out_r[g] <= upd_r[3*g+1];
          pad_oe_r[g]  <= upd_r[3*g+2];
        end else begin
          pad_out_r[g] <= core_out[g];
          pad_oe_r[g]  <= core_oe[g];
        end
      end
    end
  endgenerate

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      keeper_en_r <= 1'b1;
    end else begin
      keeper_en_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // User chain access
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      user_state_r   <= S_RESET;
      user_sel_a_r   <= 1'b0;
      user_sel_b_r   <= 1'b0;
      user_tdi_r     <= 1'b0;
      user_capture_r <= 1'b0;
      user_shift_r   <= 1'b0;
      user_update_r  <= 1'b0;
    end else begin
      user_state_r   <= state_r;
      user_sel_a_r   <= (ir_r == `JBST_OP_CHAIN_A);
      user_sel_b_r   <= (ir_r == `JBST_OP_CHAIN_B);
      user_tdi_r     <= tdi_s_r[1];
      // scan strobes go to user logic
      user_capture_r <= step & sel_chain & (state_r == S_CAP_DR);
      user_shift_r   <= step & ushift;
      user_update_r  <= tck_fall & sel_chain & (state_r == S_UPD_DR);
    end
  end

  jbst_fifo #(
    .WIDTH (`JBST_FIFO_WIDTH),
    .DEPTH (`JBST_FIFO_DEPTH),
    .AW    (`JBST_FIFO_AW)
  ) u_fifo (
    .clk       (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (step & ushift),
    .in_ready  (fifo_rdy),
    .in_data   ({(ir_r == `JBST_OP_CHAIN_B), tdi_s_r[1]}),
    .out_valid (ubit_valid),
    .out_ready (ubit_ready),
    .out_data  (ubit_data)
  );

  // BSR_LEN per variant: 240, 480, 636, 816
  wire unused_ok = ir_known;
endmodule // jbst_tap

// ==== tb/jbst_host_model.sv ====
`timescale 1ns/10ps
module jbst_host_model (
  // Clock
  input  logic ref_clk,
  // Test port
  output logic tck,
  output logic tms,
  output logic tdi,
  input  logic tdo
);
  // Raised by the bench to act as a slow tester
  int low_cyc = 6;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  task automatic step(input logic m, input logic d, output logic q);
    @(negedge ref_clk);
    tms = m;
    tdi = d;
    repeat (low_cyc) @(negedge ref_clk);
    q = tdo;
    tck = 1'b1;
    repeat (6) @(negedge ref_clk);
    tck = 1'b0;
  endtask

  task automatic reset_tap();
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask

  task automatic scan(input logic ir, input logic [255:0] din, input int n,
                      output logic [255:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir)
      step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule // jbst_host_model

// ==== tb/jbst_tap_checker.sv ====
`timescale 1ns/10ps
module jbst_tap_checker #(
  parameter NPIN = 80
) (
  // Clock and reset
  input logic            ref_clk,
  input logic            rst_n,
  // Test port
  input logic            tck,
  input logic            tdo_r,
  input logic            tdo_oe_r,
  // Pads and modes
  input logic [NPIN-1:0] core_out,
  input logic [NPIN-1:0] pad_out_r,
  input logic [NPIN-1:0] pad_oe_r,
  input logic            keeper_en_r,
  input logic            isc_mode_r,
  // User chains
  input logic [3:0]      user_state_r,
  input logic            user_sel_a_r,
  input logic            user_sel_b_r,
  input logic            user_capture_r,
  input logic            user_shift_r,
  input logic            user_update_r,
  input logic            ubit_valid,
  input logic            ubit_ready,
  input logic [1:0]      ubit_data
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_keeper_on: assert property (keeper_en_r)
    else $error("keeper enable low");
  a_isc_float: assert property (isc_mode_r [*2] |-> pad_oe_r == '0)
    else $error("pads driven in programming mode");
  a_chain_excl: assert property (!(user_sel_a_r && user_sel_b_r))
    else $error("both user chains selected");
  a_oe_shift: assert property ($rose(tdo_oe_r) |->
      (user_state_r == 4'h2 || user_state_r == 4'hA))
    else $error("scan out enabled outside shift");
  a_tdo_fall: assert property ($changed(tdo_r) |-> !tck && !$past(tck, 2))
    else $error("scan out moved away from falling tck");
  a_ubit_hold: assert property (ubit_valid && !ubit_ready |=>
      ubit_valid && $stable(ubit_data))
    else $error("user bit dropped while stalled");
  a_pulse_one: assert property (user_capture_r || user_update_r |=>
      !user_capture_r && !user_update_r)
    else $error("user pulse longer than one cycle");
  a_shift_sel: assert property (user_shift_r |-> user_sel_a_r || user_sel_b_r)
    else $error("user shift without user chain");
  a_reset_tlr: assert property ($rose(rst_n) |->
      user_state_r == 4'hF && !tdo_oe_r)
    else $error("state not reset");
  a_pad_follow: assert property ($rose(rst_n) |=> pad_out_r == $past(core_out))
    else $error("pads not following core");
endmodule // jbst_tap_checker

bind jbst_tap jbst_tap_checker #(.NPIN(NPIN)) chk_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .tck(tck), .tdo_r(tdo_r), .tdo_oe_r(tdo_oe_r),
  .core_out(core_out), .pad_out_r(pad_out_r), .pad_oe_r(pad_oe_r),
  .keeper_en_r(keeper_en_r), .isc_mode_r(isc_mode_r), .user_state_r(user_state_r),
  .user_sel_a_r(user_sel_a_r), .user_sel_b_r(user_sel_b_r),
  .user_capture_r(user_capture_r), .user_shift_r(user_shift_r),
  .user_update_r(user_update_r), .ubit_valid(ubit_valid), .ubit_ready(ubit_ready),
  .ubit_data(ubit_data)
);

// ==== tb/jbst_tap_tb.sv ====
`timescale 1ns/10ps
`include "jbst_defs.vh"
module jbst_tap_tb;
  // Arbitrary identity values, not any real part
  localparam logic [3:0]  ID_V = 4'h3;
  localparam logic [15:0] ID_P = 16'hBEEF;
  localparam logic [10:0] ID_M = 11'h2B1;
  localparam logic [31:0] ID_WORD = {ID_V, ID_P, ID_M, 1'b1};

  logic         ref_clk, rst_n, tck, tms, tdi, tdo, tdo_oe, usercode_set;
  logic         user_tdo_a, user_tdo_b, ubit_ready, ubit_valid, keeper_en_r;
  logic         isc_mode_r, user_sel_a_r, user_sel_b_r;
  logic [31:0]  usercode_cfg;
  logic [79:0]  pin_in, core_out, core_oe, pad_out_r, pad_oe_r, cap;
  logic [3:0]   user_state_r;
  logic [1:0]   ubit_data;
  logic [255:0] dout, pre;
  int           error_cnt, num_checks;

  jbst_tap #(.ID_VERSION(ID_V), .ID_PART(ID_P), .ID_MFR(ID_M)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo_r(tdo),
    .tdo_oe_r(tdo_oe), .usercode_cfg(usercode_cfg), .usercode_set(usercode_set),
    .pin_in(pin_in), .core_out(core_out), .core_oe(core_oe), .pad_out_r(pad_out_r),
    .pad_oe_r(pad_oe_r), .keeper_en_r(keeper_en_r), .isc_mode_r(isc_mode_r),
    .user_state_r(user_state_r), .user_sel_a_r(user_sel_a_r),
    .user_sel_b_r(user_sel_b_r), .user_tdi_r(), .user_capture_r(), .user_shift_r(),
    .user_update_r(), .user_tdo_a(user_tdo_a), .user_tdo_b(user_tdo_b),
    .ubit_valid(ubit_valid), .ubit_ready(ubit_ready), .ubit_data(ubit_data));
  jbst_host_model host_u (.ref_clk(ref_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic load_ir(input logic [9:0] code);
    host_u.scan(1'b1, {246'd0, code}, 10, dout);
    check(dout[9:0], `JBST_IR_CAPTURE);
  endtask
  task automatic scan_dr(input logic [255:0] din, input int n);
    host_u.scan(1'b0, din, n, dout);
  endtask
  task automatic drain(input logic [7:0] bits, input logic chb);
    for (int i = 0; i < 8; i++) begin
      @(negedge ref_clk);
      check({ubit_valid, ubit_data}, {1'b1, chb, bits[i]});
      ubit_ready = 1'b1;
      @(negedge ref_clk);
      ubit_ready = 1'b0;
    end
    repeat (2) @(negedge ref_clk);
    check(ubit_valid, 1'b0);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_id();
    scan_dr('0, 32);
    check(dout[31:0], ID_WORD);
    load_ir(`JBST_OP_IDCODE);
    scan_dr('1, 33);
    check(dout[32:0], {1'b1, ID_WORD});
    check(dout[0], 1'b1);
    $display("test id done");
  endtask
  task automatic t_code();
    load_ir(`JBST_OP_USERCODE);
    scan_dr('0, 32);
    check(dout[31:0], 32'hFFFF_FFFF);
    @(negedge ref_clk);
    usercode_cfg = 32'h5A3C_0F96;
    usercode_set = 1'b1;
    host_u.low_cyc = 15;
    scan_dr('0, 32);
    check(dout[31:0], 32'h5A3C_0F96);
    host_u.low_cyc = 6;
    $display("test usercode done");
  endtask
  task automatic t_bypass();
    for (int i = 0; i < 3; i++) begin
      load_ir(i == 0 ? `JBST_OP_BYPASS : i == 1 ? `JBST_OP_HIGHZ : `JBST_OP_CLAMP);
      scan_dr(256'h96, 8);
      check(dout[7:0], 8'h2C);
      if (i == 1)
        check({keeper_en_r, pad_oe_r}, {1'b1, 80'h0});
    end
    $display("test bypass done");
  endtask
  task automatic t_bsr();
    // Clamp from the last scenario still holds the pads until SAMPLE lands
    load_ir(`JBST_OP_SAMPLE);
    check(pad_out_r, core_out);
    pre = '0;
    for (int i = 0; i < 80; i++) begin
      pre[3*i+1] = core_oe[i];
      pre[3*i+2] = core_out[i];
    end
    scan_dr(pre, 240);
    for (int i = 0; i < 80; i++)
      cap[i] = dout[3*i];
    check(cap, pin_in);
    load_ir(`JBST_OP_EXTEST);
    check({pad_out_r, pad_oe_r}, {core_oe, core_out});
    @(negedge ref_clk);
    pin_in = ~pin_in;
    scan_dr(pre, 240);
    for (int i = 0; i < 80; i++)
      cap[i] = dout[3*i];
    check(cap, pin_in);
    load_ir(`JBST_OP_CLAMP);
    check({pad_out_r, pad_oe_r, keeper_en_r}, {core_oe, core_out, 1'b1});
    $display("test boundary done");
  endtask
  task automatic t_user();
    load_ir(`JBST_OP_CHAIN_A);
    check({user_sel_a_r, user_sel_b_r}, 2'b10);
    scan_dr(256'hB4, 8);
    check(dout[7:0], 8'hFF);
    drain(8'hB4, 1'b0);
    load_ir(`JBST_OP_CHAIN_B);
    check({user_sel_a_r, user_sel_b_r}, 2'b01);
    scan_dr(256'h3C, 8);
    check(dout[7:0], 8'h00);
    drain(8'h3C, 1'b1);
    $display("test user chains done");
  endtask
  task automatic t_isc();
    load_ir(`JBST_OP_ISC_ENTER);
    check({isc_mode_r, pad_oe_r}, {1'b1, 80'h0});
    load_ir(`JBST_OP_ISC_EXIT);
    check(isc_mode_r, 1'b0);
    $display("test programming done");
  endtask
  task automatic t_reset();
    load_ir(`JBST_OP_CHAIN_A);
    host_u.reset_tap();
    check({user_sel_a_r, user_state_r}, {1'b0, 4'hC});
    @(negedge ref_clk);
    rst_n = 1'b0;
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    check(user_state_r, 4'hF);
    $display("test reset done");
  endtask

  initial begin
    error_cnt = 0;
    num_checks = 0;
    rst_n = 1'b0;
    usercode_cfg = 32'h0000_0000;
    usercode_set = 1'b0;
    user_tdo_a = 1'b1;
    user_tdo_b = 1'b0;
    ubit_ready = 1'b0;
    pin_in = 80'h9669_6996_ABCD_EF01_2345;
    core_out = 80'hA5A5_5A5A_C3C3_3C3C_0FF0;
    core_oe = 80'h0F0F_F0F0_1234_8765_FF00;
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    // Scan walks start from idle, not from test-logic-reset
    host_u.reset_tap();
    t_id();
    t_code();
    t_bypass();
    t_bsr();
    t_user();
    t_isc();
    t_reset();
    finish_test();
  end

  // Whole run is near 50 us; allow six times that
  initial begin
    #300_000;
    error_cnt++;
    finish_test();
  end
endmodule // jbst_tap_tb
